// File: rtl/mpfm_regs.svh
// Purpose: Constants for the mode pin function multiplexer.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef MPFM_REGS_SVH
`define MPFM_REGS_SVH
// Mode codes, {mode_select_b, mode_select_a} sampled on the first enabled edge after reset release.
`define MPFM_MODE_BOOT 2'h0
`define MPFM_MODE_SINGLE 2'h1
`define MPFM_MODE_TEST 2'h2
`define MPFM_MODE_EXPANDED 2'h3
// Port widths.
`define MPFM_PORT_W 8
`define MPFM_PORTD_W 6
// Drive-high pulse of the instruction-start pin, in ns and in cycles.
`define MPFM_DRIVE_HIGH_NS 40
`define MPFM_CLK_NS 40
`define MPFM_DRIVE_HIGH_CYC \
   ((`MPFM_DRIVE_HIGH_NS + `MPFM_CLK_NS - 1) / `MPFM_CLK_NS)
// Bit of the second option register that controls the indicator.
`define MPFM_OPTION_REG_TWO_DRIVE_HIGH_BIT 4
// Port data register reset value.
`define MPFM_PORT_RESET 8'h00
`endif

// File: rtl/mpfm_pkg.sv
// Purpose: Types for the mode pin function multiplexer.
// Assumes: Nothing.
// Notes: Constants live in mpfm_regs.svh.
package mpfm_pkg;
   typedef enum logic [1:0] {
      MPFM_BOOT = 2'b00,
      MPFM_SINGLE = 2'b01,
      MPFM_TEST = 2'b10,
      MPFM_EXPANDED = 2'b11
   } mpfm_mode_type;
   typedef enum logic [1:0] {
      MPFM_ST_RESET = 2'b00,
      MPFM_ST_IDLE = 2'b01,
      MPFM_ST_LOW = 2'b10,
      MPFM_ST_HIGH = 2'b11
   } mpfm_ind_state_type;
endpackage : mpfm_pkg

// File: rtl/mpfm_gpio_port.sv
// Purpose: One 8-bit general-purpose port with data and direction latches.
// Assumes: Writes come from internal logic, synchronous to clk_i.
// Notes: Bus override selects a mode-dependent alternate function.
`timescale 1ns/100ps
`default_nettype none
`include "mpfm_regs.svh"
module mpfm_gpio_port #(
   parameter int WIDTH = `MPFM_PORT_W
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register access.
   input wire logic data_we_i,
   input wire logic dir_we_i,
   input wire logic [WIDTH-1:0] wdata_i,
   // Mode override.
   input wire logic bus_mode_i,
   input wire logic [WIDTH-1:0] bus_out_i,
   input wire logic [WIDTH-1:0] bus_oe_i,
   // Pins.
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] pin_o,
   output logic [WIDTH-1:0] pin_oe_o,
   output logic [WIDTH-1:0] rdata_o
);
   typedef struct packed {
      logic [WIDTH-1:0] data;
      logic [WIDTH-1:0] dir;
      logic [WIDTH-1:0] out;
      logic [WIDTH-1:0] oe;
      logic [WIDTH-1:0] rd;
   } mpfm_port_state_type;
   mpfm_port_state_type s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (data_we_i) begin
         s_d.data = wdata_i;
      end
      if (dir_we_i) begin
         s_d.dir = wdata_i;
      end
      // Bus mode overrides the latches, which keep their values.
      if (bus_mode_i) begin
         s_d.out = bus_out_i;
         s_d.oe = bus_oe_i;
      end else begin
         s_d.out = s_d.data;
         s_d.oe = s_d.dir;
      end
      // Driven bits read back the driver input, so a bus function reads
      // as such; released bits read the pin.
      s_d.rd = (s_d.oe & s_d.out) | (~s_d.oe & pin_i);
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
   assign pin_o = s_q.out;
   assign pin_oe_o = s_q.oe;
   assign rdata_o = s_q.rd;
endmodule : mpfm_gpio_port
`default_nettype wire

// File: rtl/mpfm_mode_pin_mux.sv
// Purpose: Mode capture and mode-dependent pin function selection.
// Assumes: All inputs synchronous to clk_i, the bus-cycle clock.
// Notes: Pins are split into input, output and output enable.
//
// Summary of operation
// - Mode pins are sampled on the first enabled edge after reset release and decoded into four modes.
// - After mode choice, mode pin A becomes an open-drain instruction flag.
// - Instruction flag pulls low during the opcode fetch cycle.
// - With drive-high enabled, the flag is driven high for a short time.
// - The drive-high enable is a bit of the second option register.
// - Single chip and bootstrap modes use the shared pin as port G bit 7.
// - Expanded and test modes drive the shared pin high for read, low write.
// - Ports B, C, F and G bit 7 are general I/O only in non-bus modes.
// - Seven 8-bit ports and one 6-bit port; port E is input only.
// - At reset every general-purpose input pin is high impedance.
// - Port data reads reflect the driven function on driven bits, pins on released bits.
// - Port A is an 8-bit I/O port with data and direction registers.
// - Port A is shared with the timer and readable at any time.
// - Expanded mode drives port B as address lines 15 to 8.
// - Expanded mode uses port C as the bidirectional data bus.
// - Expanded mode drives port F as address lines 7 to 0.
`timescale 1ns/100ps
`default_nettype none
`include "mpfm_regs.svh"
module mpfm_mode_pin_mux #(
   parameter int W = `MPFM_PORT_W,
   parameter int WD = `MPFM_PORTD_W
) (
   // Clock, enable and reset.
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic rst_n_i,
   // Mode pins.
   input wire logic mode_select_a_i,
   input wire logic mode_select_b_i,
   output logic instr_start_indicator_o,
   output logic instr_start_indicator_oe_o,
   // Core side: option register and instruction start.
   input wire logic [7:0] option_reg_two_i,
   input wire logic opcode_fetch_i,
   // Core side: external bus request.
   input wire logic [15:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_read_i,
   input wire logic bus_active_i,
   output logic [7:0] bus_rdata_o,
   output logic [1:0] mode_o,
   // Core side: port register writes, one select bit per port.
   input wire logic [6:0] data_we_i,
   input wire logic [6:0] dir_we_i,
   input wire logic [7:0] wdata_i,
   // Timer alternate function on port A.
   input wire logic [W-1:0] timer_out_i,
   input wire logic [W-1:0] timer_oe_i,
   // Port pins A, B, C, D, F, G, H in that order.
   input wire logic [7*W-1:0] port_pin_i,
   output logic [7*W-1:0] port_pin_o,
   output logic [7*W-1:0] port_pin_oe_o,
   output logic [7*W-1:0] port_rdata_o,
   // Port E, input only.
   input wire logic [W-1:0] port_e_pin_i,
   output logic [W-1:0] port_e_rdata_o
);
   typedef struct packed {
      mpfm_pkg::mpfm_mode_type mode;
      logic in_reset;
      mpfm_pkg::mpfm_ind_state_type ind;
      logic [7:0] hi_cnt;
      logic ind_out;
      logic ind_oe;
      logic rw;
      logic [W-1:0] pe;
      logic [7:0] rdata;
   } mpfm_state_type;
   mpfm_state_type s_q, s_d;

   localparam logic [7:0] HI_CYC = 8'(`MPFM_DRIVE_HIGH_CYC);

   function automatic logic is_bus(input mpfm_pkg::mpfm_mode_type m);
      is_bus = (m == mpfm_pkg::MPFM_EXPANDED) || (m == mpfm_pkg::MPFM_TEST);
   endfunction : is_bus

   // ****************************************
   // Mode capture and instruction indicator
   // ****************************************
   logic bus_mode;
   assign bus_mode = is_bus(s_q.mode);
   always_comb begin
      s_d = s_q;
      // First enabled edge after release: mode pins still hold the strap.
      if (s_q.in_reset) begin
         s_d.mode = mpfm_pkg::mpfm_mode_type'({mode_select_b_i,
            mode_select_a_i});
         s_d.in_reset = 1'b0;
         s_d.ind = mpfm_pkg::MPFM_ST_IDLE;
      end
      s_d.ind_out = 1'b0;
      s_d.ind_oe = 1'b0;
      case (s_q.ind)
         mpfm_pkg::MPFM_ST_RESET: begin
            s_d.ind_oe = 1'b0;
         end
         mpfm_pkg::MPFM_ST_IDLE, mpfm_pkg::MPFM_ST_HIGH: begin
            if (opcode_fetch_i) begin
               s_d.ind = mpfm_pkg::MPFM_ST_LOW;
               s_d.ind_oe = 1'b1;
            end else if (s_q.ind == mpfm_pkg::MPFM_ST_HIGH) begin
               s_d.hi_cnt = s_q.hi_cnt - 8'h01;
               s_d.ind_out = 1'b1;
               s_d.ind_oe = s_q.hi_cnt > 8'h01;
               if (s_q.hi_cnt <= 8'h01) begin
                  s_d.ind = mpfm_pkg::MPFM_ST_IDLE;
               end
            end
         end
         mpfm_pkg::MPFM_ST_LOW: begin
            // Drive-high lets back-to-back fetches be told apart.
            if (opcode_fetch_i) begin
               s_d.ind_oe = 1'b1;
            end else if (option_reg_two_i[`MPFM_OPTION_REG_TWO_DRIVE_HIGH_BIT]) begin
               s_d.ind = mpfm_pkg::MPFM_ST_HIGH;
               s_d.hi_cnt = HI_CYC;
               s_d.ind_out = 1'b1;
               s_d.ind_oe = 1'b1;
            end else begin
               s_d.ind = mpfm_pkg::MPFM_ST_IDLE;
            end
         end
         default: begin
            s_d.ind = mpfm_pkg::MPFM_ST_IDLE;
         end
      endcase
      s_d.pe = port_e_pin_i;
      s_d.rdata = port_pin_i[2*W +: W];
      // Registered so the strobe pin comes from a flip-flop like the bus.
      s_d.rw = bus_read_i | ~bus_active_i;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.in_reset <= 1'b1;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
   assign instr_start_indicator_o = s_q.ind_out;
   assign instr_start_indicator_oe_o = s_q.ind_oe;
   assign port_e_rdata_o = s_q.pe;
   assign bus_rdata_o = s_q.rdata;
   assign mode_o = s_q.mode;

   // ****************************************
   // Ports
   // ****************************************
   logic [7*W-1:0] bus_out, bus_oe;
   logic [6:0] bus_sel;
   always_comb begin
      bus_out = '0;
      bus_oe = '0;
      bus_sel = '0;
      bus_sel[0] = 1'b1;
      bus_out[0 +: W] = timer_out_i;
      bus_oe[0 +: W] = timer_oe_i;
      bus_sel[1] = bus_mode;
      bus_out[W +: W] = bus_addr_i[15:8];
      bus_oe[W +: W] = {W{bus_mode}};
      bus_sel[2] = bus_mode;
      bus_out[2*W +: W] = bus_wdata_i;
      bus_oe[2*W +: W] = {W{bus_mode & bus_active_i & ~bus_read_i}};
      bus_sel[4] = bus_mode;
      bus_out[4*W +: W] = bus_addr_i[7:0];
      bus_oe[4*W +: W] = {W{bus_mode}};
      bus_sel[5] = 1'b0;
   end
   logic [7*W-1:0] g_out, g_oe;
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_port
         mpfm_gpio_port #(.WIDTH(W)) u_port (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .data_we_i(data_we_i[gi]),
            .dir_we_i(dir_we_i[gi]),
            .wdata_i(wdata_i),
            .bus_mode_i(bus_sel[gi] & (gi != 0 || |timer_oe_i)),
            .bus_out_i(bus_out[gi*W +: W]),
            .bus_oe_i(bus_oe[gi*W +: W]),
            .pin_i(port_pin_i[gi*W +: W]),
            .pin_o(g_out[gi*W +: W]),
            .pin_oe_o(g_oe[gi*W +: W]),
            .rdata_o(port_rdata_o[gi*W +: W])
         );
      end
   endgenerate
   // Port G bit 7 switches to the direction strobe; port D is six bits.
   always_comb begin
      port_pin_o = g_out;
      port_pin_oe_o = g_oe;
      port_pin_o[5*W + 7] = bus_mode ? s_q.rw : g_out[5*W + 7];
      port_pin_oe_o[5*W + 7] = bus_mode ? 1'b1 : g_oe[5*W + 7];
      port_pin_o[3*W + WD +: W - WD] = '0;
      port_pin_oe_o[3*W + WD +: W - WD] = '0;
   end

   // ****************************************
   // Checks
   // ****************************************
   // The indicator walks from fetch to release or drive-high, then idle.
   sequence seq_fetch;
      ce_i && opcode_fetch_i && !s_q.in_reset;
   endsequence
   sequence seq_release;
      ce_i && s_q.ind == mpfm_pkg::MPFM_ST_LOW && !opcode_fetch_i &&
         !option_reg_two_i[`MPFM_OPTION_REG_TWO_DRIVE_HIGH_BIT];
   endsequence
   sequence seq_drive_high;
      ce_i && s_q.ind == mpfm_pkg::MPFM_ST_LOW && !opcode_fetch_i &&
         option_reg_two_i[`MPFM_OPTION_REG_TWO_DRIVE_HIGH_BIT];
   endsequence
   sequence seq_bus_steady;
      ce_i && bus_mode ##1 bus_mode;
   endsequence
   AST_MODE_HELD: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !s_q.in_reset && ce_i |=> $stable(mode_o))
      else $error("Mode changed after capture.");
   AST_FETCH_LOW: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      seq_fetch |=> instr_start_indicator_oe_o && !instr_start_indicator_o)
      else $error("Indicator not low on fetch.");
   AST_OPEN_DRAIN: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      seq_release |=> !instr_start_indicator_oe_o)
      else $error("Indicator driven while open drain.");
   AST_DRIVE_HIGH: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      seq_drive_high |=> instr_start_indicator_oe_o && instr_start_indicator_o)
      else $error("Indicator not driven high.");
   AST_HIGH_SHORT: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      seq_drive_high ##1 (ce_i && !opcode_fetch_i) |=>
      !instr_start_indicator_oe_o)
      else $error("Indicator driven high too long.");
   AST_RW_DIR: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && bus_mode |=> port_pin_oe_o[5*W + 7] &&
      port_pin_o[5*W + 7] == ($past(bus_read_i) | ~$past(bus_active_i)))
      else $error("Direction strobe wrong.");
   AST_DATA_DIR: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && bus_mode |=> port_pin_oe_o[2*W +: W] == {W{$past(bus_active_i) &
      ~$past(bus_read_i)}})
      else $error("Data bus direction wrong.");
   AST_ADDR_HI: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      seq_bus_steady |-> port_pin_o[W +: W] == $past(bus_addr_i[15:8]))
      else $error("High address wrong.");
   AST_ADDR_LO: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      seq_bus_steady |-> port_pin_o[4*W +: W] == $past(bus_addr_i[7:0]))
      else $error("Low address wrong.");
   AST_PORTD_TOP: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      port_pin_oe_o[3*W + WD +: W - WD] == '0)
      else $error("Missing port D bits driven.");
endmodule : mpfm_mode_pin_mux
`default_nettype wire

// File: bench/mpfm_ext_mem.sv
// Purpose: External memory model on the expanded bus of the pin mux.
// Assumes: Address on ports B and F, data on port C, direction on G7.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module mpfm_ext_mem (
   // Clock and enable.
   input wire logic clk_i,
   input wire logic en_i,
   // Bus pins as driven by the device.
   input wire logic [15:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic data_oe_i,
   input wire logic rw_i,
   // Data returned to the device.
   output logic [7:0] data_o,
   output logic drive_o
);
   logic [7:0] mem [256];
   logic [7:0] last_q = 8'h00;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00;
      end
   end
   // Drive only while the device reads and has let go of the bus.
   assign drive_o = en_i & rw_i & ~data_oe_i;
   assign data_o = drive_o ? mem[addr_i[7:0]] : ~last_q;
   always @(posedge clk_i) begin
      if (drive_o) begin
         last_q <= data_o;
      end
      if (en_i && !rw_i && data_oe_i) begin
         mem[addr_i[7:0]] <= data_i;
      end
   end
endmodule : mpfm_ext_mem
`default_nettype wire

// File: bench/mpfm_mode_pin_mux_test.sv
// Purpose: Self-checking bench for the mode pin function multiplexer.
// Assumes: Port bytes ordered A, B, C, D, F, G, H from byte 0.
// Notes: Open-drain pins are pulled high; port C follows the memory model.
`timescale 1ns/100ps
`default_nettype none
`include "mpfm_regs.svh"
module mpfm_mode_pin_mux_test;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sa = 1'b1, sb = 1'b1, fetch = 1'b0, bread = 1'b0, bact = 1'b0;
   logic exp_en = 1'b0, ind_o, ind_oe;
   logic [7:0] tmr_out = 8'h00, tmr_oe = 8'h00;
   logic [7:0] option_reg_two = 8'h00, bwdata = 8'h00, wdata = 8'h00, rdata, mem_d;
   logic [7:0] ext_e = 8'h69;
   logic [15:0] baddr = 16'h0000;
   logic [6:0] dwe = 7'h00, dirwe = 7'h00;
   logic [1:0] mode;
   logic [55:0] ext = 56'h0, mix, pin_o, pin_oe, pin_i, prd;
   logic [7:0] erd;
   logic g7;
   int miscompares = 0;
   int tests_run = 0;
   // Wired levels: whoever enables wins, otherwise the external level; G7 has a pull-up.
   assign mix = exp_en ? {ext[55:24], mem_d, ext[15:0]} : ext;
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & mix);
   assign g7 = pin_oe[47] ? pin_o[47] : 1'b1;
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   mpfm_mode_pin_mux mpfm_mode_pin_mux_inst (
      .clk_i(clk_i), .ce_i(1'b1), .rst_n_i(rst_n_i),
      .mode_select_a_i(ind_oe ? ind_o : sa), .mode_select_b_i(sb),
      .instr_start_indicator_o(ind_o), .instr_start_indicator_oe_o(ind_oe),
      .option_reg_two_i(option_reg_two), .opcode_fetch_i(fetch),
      .bus_addr_i(baddr), .bus_wdata_i(bwdata), .bus_read_i(bread),
      .bus_active_i(bact), .bus_rdata_o(rdata), .mode_o(mode),
      .data_we_i(dwe), .dir_we_i(dirwe), .wdata_i(wdata),
      .timer_out_i(tmr_out), .timer_oe_i(tmr_oe),
      .port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe_o(pin_oe),
      .port_rdata_o(prd), .port_e_pin_i(ext_e), .port_e_rdata_o(erd));
   mpfm_ext_mem mpfm_ext_mem_inst (
      .clk_i(clk_i), .en_i(exp_en), .addr_i({pin_o[15:8], pin_o[39:32]}),
      .data_i(pin_o[23:16]), .data_oe_i(&pin_oe[23:16]), .rw_i(g7),
      .data_o(mem_d), .drive_o());
   // ***********************************
   // Shared tasks
   // ***********************************
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk_i);
         #2;
      end
   endtask : cyc
   task automatic compare(input logic [15:0] got, input logic [15:0] exp,
                          input string what);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got,
                  exp);
      end
   endtask : compare
   task automatic do_reset(input logic [1:0] m);
      rst_n_i = 1'b0;
      {sb, sa} = m;
      cyc(3);
      compare({14'h0, |pin_oe, ind_oe}, 16'h0, "reset drive");
      rst_n_i = 1'b1;
      cyc(2);
      {sb, sa} = {~m[1], 1'b1};
      cyc(2);
      compare({14'h0, mode}, {14'h0, m}, "mode");
   endtask : do_reset
   task automatic wr_port(input int p, input logic [7:0] dir,
                          input logic [7:0] d);
      dirwe[p] = 1'b1;
      wdata = dir;
      cyc(1);
      dirwe[p] = 1'b0;
      dwe[p] = 1'b1;
      wdata = d;
      cyc(1);
      dwe[p] = 1'b0;
   endtask : wr_port
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         do_reset(2'(m));
      end
      $display("Test modes done");
   endtask : t_modes
   task automatic t_gpio;
      do_reset(mpfm_pkg::MPFM_SINGLE);
      ext[7:0] = 8'h3c;
      wr_port(1, 8'hff, 8'ha5);
      wr_port(5, 8'h80, 8'h80);
      compare({pin_oe[15:8], pin_o[15:8]}, 16'hffa5, "port b");
      compare({15'h0, g7}, 16'h1, "g7 io high");
      wr_port(5, 8'h80, 8'h00);
      compare({15'h0, g7}, 16'h0, "g7 io low");
      compare({8'h0, prd[7:0]}, 16'h003c, "port a read");
      tmr_out = 8'h05;
      tmr_oe = 8'h0f;
      cyc(1);
      compare({pin_oe[7:0], pin_o[7:0]}, 16'h0f05, "timer pins");
      compare({8'h0, prd[7:0]}, 16'h0035, "port a shared");
      tmr_oe = 8'h00;
      compare({8'h0, erd}, 16'h0069, "port e read");
      $display("Test gpio done");
   endtask : t_gpio
   task automatic t_bus;
      do_reset(mpfm_pkg::MPFM_EXPANDED);
      exp_en = 1'b1;
      wr_port(1, 8'hff, 8'h00);
      baddr = 16'h1234;
      bwdata = 8'h5a;
      bact = 1'b1;
      cyc(1);
      compare({pin_o[15:8], pin_o[39:32]}, 16'h1234, "address");
      compare({8'h0, prd[15:8]}, 16'h0012, "port b function");
      compare({pin_oe[23:16], pin_o[23:16]}, 16'hff5a, "wdata");
      compare({15'h0, g7}, 16'h0, "write strobe");
      cyc(1);
      bread = 1'b1;
      cyc(1);
      compare({pin_oe[23:16], 7'h0, g7}, 16'h0001, "read strobe");
      cyc(1);
      compare({8'h0, rdata}, 16'h005a, "read data");
      bact = 1'b0;
      bread = 1'b0;
      $display("Test bus done");
   endtask : t_bus
   task automatic t_ind;
      for (int dh = 0; dh < 2; dh++) begin
         option_reg_two = 8'(dh) << `MPFM_OPTION_REG_TWO_DRIVE_HIGH_BIT;
         fetch = 1'b1;
         cyc(1);
         compare({14'h0, ind_oe, ind_o}, 16'h2, "fetch low");
         fetch = 1'b0;
         cyc(1);
         compare({14'h0, ind_oe, ind_o}, 16'(3 * dh), "after");
         cyc(1);
         compare({15'h0, ind_oe}, 16'h0, "released");
      end
      $display("Test indicator done");
   endtask : t_ind
   initial begin
      t_modes();
      t_gpio();
      t_bus();
      t_ind();
      tally_and_finish();
   end
   // A hang counts as a mismatch and still reaches the report.
   initial begin
      repeat (5000) @(posedge clk_i);
      miscompares++;
      tally_and_finish();
   end
endmodule : mpfm_mode_pin_mux_test
`default_nettype wire
